// file: ocp_consts.svh
// timing counts and fault counter limits for the overcurrent hiccup block
`ifndef OCP_CONSTS_SVH
`define OCP_CONSTS_SVH
`define OCP_CLK_PERIOD_NS 50
`define OCP_BLANK_TIME_NS 125
`define OCP_BLANK_CYCLES ((`OCP_BLANK_TIME_NS) / (`OCP_CLK_PERIOD_NS))
`define OCP_FAULT_LIMIT 3'h7
`define OCP_HICCUP_CYCLES 3'h7
`define OCP_CNT_W 3
`define OCP_BLANK_W 4
`endif

// file: ocp_pkg.sv
// types for the overcurrent hiccup block
package ocp_pkg;
	typedef enum logic [1:0] {ST_RUN, ST_HICCUP} mode_t;
endpackage : ocp_pkg

// file: ocp_stage.sv
// power stage model: switch node and overcurrent comparator
`timescale 1ns/100ps
`default_nettype none
module ocp_stage(
	input wire logic i_clock,
	input wire logic i_drive,
	input wire logic i_short,
	output logic o_sw_high,
	output logic o_oc
);
	always_ff @(posedge i_clock)
	begin
		o_sw_high <= i_drive && !i_short;
		o_oc <= i_drive && i_short;
	end
endmodule : ocp_stage
`default_nettype wire

// file: ocp_sva.sv
// assertion checker for the overcurrent hiccup block
`timescale 1ns/100ps
`default_nettype none
module ocp_sva(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_pwm_on,
	input wire logic o_high_side_gate_drive,
	input wire logic o_low_side_gate_drive,
	input wire logic o_limit_threshold_node_low,
	input wire logic o_modulator_enable,
	input wire logic o_fault,
	input wire logic [2:0] o_fault_count
);
	wire hs = o_high_side_gate_drive;
	wire bl = o_limit_threshold_node_low;
	wire [2:0] c = o_fault_count;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	AST_OFF: assert property (o_fault |-> !hs && !o_low_side_gate_drive)
		else $error("drive on in fault");
	AST_MOD: assert property (o_fault |-> !o_modulator_enable)
		else $error("modulator on in fault");
	AST_SEVEN: assert property (c == 3'h7 |-> ##[0:2] o_fault)
		else $error("no fault at seven");
	AST_STEP: assert property ($changed(c) |-> c + 3'h1 == $past(c) || c == $past(c) + 3'h1)
		else $error("count jump");
	AST_SAT: assert property (!o_fault && c == 3'h0 |=> c <= 3'h1)
		else $error("count below zero");
	AST_BLANK: assert property ($rose(hs) |-> bl || $past(bl))
		else $error("no blanking at turn-on");
	AST_TMO: assert property (bl |-> ##[1:4] !bl)
		else $error("blanking too long");
	AST_CMD: assert property (!i_pwm_on [*4] |-> !hs)
		else $error("drive without command");
	cover property (o_fault);
	cover property ($fell(o_fault));
	cover property ($fell(hs) && i_pwm_on);
endmodule : ocp_sva
bind overcurrent_hiccup_fault_control ocp_sva i_ocp_sva(.*);
`default_nettype wire

// file: overcurrent_hiccup_fault_control.sv
// two-tier overcurrent protection: pulse termination and hiccup fault counter
`include "ocp_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module overcurrent_hiccup_fault_control
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// modulator and cycle timing
	input wire logic i_cycle_start,
	input wire logic i_pwm_on,
	input wire logic i_soft_start_done,
	// switch node comparators
	input wire logic i_switch_node_high,
	input wire logic i_overcurrent,
	// gate drives and status
	output logic o_high_side_gate_drive,
	output logic o_low_side_gate_drive,
	output logic o_limit_threshold_node_low,
	output logic o_modulator_enable,
	output logic o_fault,
	output logic [`OCP_CNT_W-1:0] o_fault_count
);
	localparam logic [`OCP_BLANK_W-1:0] BLANK_MAX = `OCP_BLANK_W'(`OCP_BLANK_CYCLES);
	localparam int SYNC_N = 2;
	// raw comparator pins, one synchroniser each
	logic [SYNC_N-1:0] pin_async;
	logic [SYNC_N-1:0] pin_meta_reg;
	logic [SYNC_N-1:0] pin_sync_reg;
	logic sw_high;
	logic oc_raw;

	// mode and counter
	ocp_pkg::mode_t mode_reg;
	logic [`OCP_CNT_W-1:0] count_reg;

	// blanking window
	logic [`OCP_BLANK_W-1:0] blank_cnt_reg;
	logic blank_reg;

	// pulse state
	logic hs_reg;
	logic ls_reg;
	logic tripped_reg;
	logic trip_cycle_reg;
	logic pwm_prev_reg;

	// decoded conditions
	logic turn_on;
	logic trip;
	logic in_run;
	logic at_limit;
	logic drive_ok;

	assign pin_async = {i_overcurrent, i_switch_node_high};
	assign sw_high = pin_sync_reg[0];
	assign oc_raw = pin_sync_reg[1];
	assign in_run = (mode_reg == ocp_pkg::ST_RUN);
	assign at_limit = (count_reg == `OCP_FAULT_LIMIT);
	// drives may only switch while running below the fault limit
	assign drive_ok = in_run && !at_limit;
	assign turn_on = drive_ok && i_pwm_on && !pwm_prev_reg && !tripped_reg;
	// trip only on high side pulse once blanking has closed
	assign trip = hs_reg && !blank_reg && oc_raw;

	// pin synchronisers, two flip-flops per comparator
	genvar g;
	generate
		for (g = 0; g < SYNC_N; g++)
		begin : gen_sync
			always_ff @(posedge i_clock or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					pin_meta_reg[g] <= 1'b0;
					pin_sync_reg[g] <= 1'b0;
				end
				else
				begin
					pin_meta_reg[g] <= pin_async[g];
					pin_sync_reg[g] <= pin_meta_reg[g];
				end
			end
		end
	endgenerate

	// previous pwm command for edge detection
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pwm_prev_reg <= 1'b0;
		end
		else
		begin
			pwm_prev_reg <= i_pwm_on;
		end
	end

	// blanking window
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			blank_reg <= 1'b0;
			blank_cnt_reg <= 4'h0;
		end
		else if (turn_on)
		begin
			blank_reg <= 1'b1;
			blank_cnt_reg <= 4'h0;
		end
		else if (blank_reg)
		begin
			blank_cnt_reg <= blank_cnt_reg + 4'h1;
			if (sw_high)
			begin
				blank_reg <= 1'b0;
			end
			else if (blank_cnt_reg + 4'h1 >= BLANK_MAX)
			begin
				blank_reg <= 1'b0;
			end
		end
	end

	// pulse termination latch, cleared by next cycle
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tripped_reg <= 1'b0;
		end
		else if (trip)
		begin
			tripped_reg <= 1'b1;
		end
		else if (i_cycle_start)
		begin
			tripped_reg <= 1'b0;
		end
	end

	// cycle contains trip
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			trip_cycle_reg <= 1'b0;
		end
		else if (i_cycle_start)
		begin
			trip_cycle_reg <= trip;
		end
		else if (trip)
		begin
			trip_cycle_reg <= 1'b1;
		end
	end

	// high side drive
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			hs_reg <= 1'b0;
		end
		else if (!drive_ok)
		begin
			hs_reg <= 1'b0;
		end
		else if (trip)
		begin
			hs_reg <= 1'b0;
		end
		else
		begin
			hs_reg <= i_pwm_on && !tripped_reg;
		end
	end

	// low side drive, complement of high side while running
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ls_reg <= 1'b0;
		end
		else if (!drive_ok)
		begin
			ls_reg <= 1'b0;
		end
		else if (trip)
		begin
			ls_reg <= 1'b1;
		end
		else
		begin
			ls_reg <= !i_pwm_on || tripped_reg;
		end
	end

	// operating mode
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mode_reg <= ocp_pkg::ST_RUN;
		end
		else
		begin
			case (mode_reg)
				ocp_pkg::ST_RUN:
				begin
					if (at_limit)
					begin
						mode_reg <= ocp_pkg::ST_HICCUP;
					end
				end
				ocp_pkg::ST_HICCUP:
				begin
					if (i_soft_start_done && (count_reg == 3'h1))
					begin
						mode_reg <= ocp_pkg::ST_RUN;
					end
				end
				default:
				begin
					mode_reg <= ocp_pkg::ST_RUN;
				end
			endcase
		end
	end

	// fault counter
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			count_reg <= 3'h0;
		end
		else if (mode_reg == ocp_pkg::ST_HICCUP)
		begin
			if (i_soft_start_done && (count_reg != 3'h0))
			begin
				count_reg <= count_reg - 3'h1;
			end
		end
		else if (i_cycle_start && !at_limit)
		begin
			if (trip_cycle_reg || trip)
			begin
				count_reg <= count_reg + 3'h1;
			end
			else if (count_reg != 3'h0)
			begin
				count_reg <= count_reg - 3'h1;
			end
		end
	end

	// high side output, forced off in fault at once
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_high_side_gate_drive <= 1'b0;
		else
			o_high_side_gate_drive <= hs_reg && drive_ok;
	end

	// low side output, forced off in fault at once
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_low_side_gate_drive <= 1'b0;
		else
			o_low_side_gate_drive <= ls_reg && drive_ok;
	end

	// threshold pulled low while blanking
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_limit_threshold_node_low <= 1'b0;
		else
			o_limit_threshold_node_low <= blank_reg;
	end

	// modulator enable
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_modulator_enable <= 1'b1;
		else
			o_modulator_enable <= drive_ok;
	end

	// fault status
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_fault <= 1'b0;
		else
			o_fault <= !drive_ok;
	end

	// counter view
	always_ff @(posedge i_clock or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_fault_count <= 3'h0;
		else
			o_fault_count <= count_reg;
	end
endmodule : overcurrent_hiccup_fault_control
`default_nettype wire

// file: test_overcurrent_hiccup_fault_control.sv
// bench for the overcurrent hiccup block
`timescale 1ns/100ps
`default_nettype none
module test_overcurrent_hiccup_fault_control;
	logic clk = 0, rst_n = 0, cs = 0, pwm = 0, ssd = 0, sh = 0, pt = 0;
	logic swh, oc, hs, ls, bl, me, flt;
	logic [2:0] cnt, ec = 0;
	int err_total = 0, num_checks = 0, cyc = 0, seed = 36, i, k;
	always #25 clk = ~clk;
	overcurrent_hiccup_fault_control i_overcurrent_hiccup_fault_control(.i_clock(clk),
		.i_rst_n(rst_n), .i_cycle_start(cs), .i_pwm_on(pwm), .i_soft_start_done(ssd),
		.i_switch_node_high(swh), .i_overcurrent(oc), .o_high_side_gate_drive(hs),
		.o_low_side_gate_drive(ls), .o_limit_threshold_node_low(bl),
		.o_modulator_enable(me), .o_fault(flt), .o_fault_count(cnt));
	ocp_stage i_ocp_stage(.i_clock(clk), .i_drive(hs), .i_short(sh), .o_sw_high(swh), .o_oc(oc));
	function logic [2:0] nxt(input logic [2:0] c, input logic t);
		return t ? c + 3'h1 : (c == 3'h0 ? c : c - 3'h1);
	endfunction : nxt
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task chk(input logic [2:0] g, input logic [2:0] e);
		num_checks++;
		if (g !== e)
		begin
			$display("FAIL %0t got %h exp %h", $time, g, e);
			err_total++;
		end
	endtask : chk
	task per(input logic s);
		@(negedge clk);
		sh = s;
		cs = 1;
		ec = nxt(ec, pt);
		pt = s && ec != 3'h7;
		@(negedge clk);
		cs = 0;
		pwm = 1;
		for (i = 0; i < 14; i++)
		begin
			@(negedge clk);
			if (i == 2) chk(cnt, ec);
			if (i == 2) chk(flt, ec == 3'h7);
			if (i == 2) chk(bl, ec != 3'h7);
			if (i == 8) chk(hs, !s && ec != 3'h7);
			if (i == 8) chk(ls, s && ec != 3'h7);
			if (i == 8) pwm = 0;
		end
	endtask : per
	task hic;
		for (k = 0; k < 7; k++)
		begin
			repeat (3) @(negedge clk);
			ssd = 1;
			@(negedge clk);
			ssd = 0;
			ec = ec - 3'h1;
			repeat (2) @(negedge clk);
			chk(cnt, ec);
			chk(hs, 0);
			chk(ls, ec == 3'h0);
			chk(flt, ec != 3'h0);
		end
		repeat (3) @(negedge clk);
		chk(me, 1);
	endtask : hic
	always @(posedge clk)
		if (++cyc > 2000)
		begin
			err_total++;
			stop_test;
		end
	initial
	begin
		repeat (12) @(negedge clk);
		rst_n = 1;
		repeat (10) per(($random(seed) & 3) == 0);
		$display("random periods done");
		while (ec != 3'h7) per(1'b1);
		$display("fault entry done");
		hic;
		per(1'b0);
		per(1'b0);
		$display("restart done");
		stop_test;
	end
endmodule : test_overcurrent_hiccup_fault_control
`default_nettype wire
